// >>> logic/sfr_pkg.sv
package sfr_pkg;

  // Read opcodes taken by the engine
  localparam logic [7:0] OPC_PLAIN      = 8'h03;
  localparam logic [7:0] OPC_PLAIN_WIDE = 8'h13;
  localparam logic [7:0] OPC_FAST       = 8'h0b;
  localparam logic [7:0] OPC_FAST_WIDE  = 8'h0c;
  localparam logic [7:0] OPC_DUAL       = 8'hbb;
  localparam logic [7:0] OPC_DUAL_WIDE  = 8'hbc;
  localparam logic [7:0] OPC_QUAD       = 8'heb;
  localparam logic [7:0] OPC_UID        = 8'h4b;
  localparam logic [7:0] OPC_INFO       = 8'h68;

  // Framing figures
  localparam logic [5:0] OPC_BITS        = 6'd8;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'd24;
  localparam logic [5:0] ADDR_BITS_WIDE  = 6'd32;
  localparam int         TOP_DECODED_BIT = 23;
  localparam logic [2:0] MODE_CLOCKS     = 3'd4;
  localparam logic [3:0] SKIP_NIBBLE     = 4'ha;
  localparam logic [4:0] DUMMY_SINGLE_RST = 5'd8;
  localparam logic [4:0] DUMMY_QUAD_RST   = 5'd6;
  localparam logic [4:0] DUMMY_DUAL_RST   = 5'd4;
  localparam int         SYNC_W           = 6;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam int         CTRL_ENABLE_BIT = 0;
  localparam logic       CTRL_ENABLE_RST = 1'b1;
  localparam int         STAT_SKIP_BIT   = 4;
  localparam int         STAT_PAUSE_BIT  = 5;
  localparam int         STAT_SEL_BIT    = 6;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
  } sfr_state_e;

  typedef enum logic [1:0] {KIND_PLAIN, KIND_FAST, KIND_DUAL} sfr_kind_e;

  // Settings handed in by the configuration and status logic
  typedef struct packed {
    logic       wideAddressFlag;
    logic [4:0] dummySingle;
    logic [4:0] dummyQuad;
    logic [4:0] dummyDual;
    logic       quadEnableBit;
    logic       fourLineCommandMode;
    logic       writeInProgress;
    logic       doubleRate;
    logic       pinIsReset;
  } sfr_cfg_s;

  typedef struct packed {
    logic      ok;
    sfr_kind_e kind;
    logic      wide;
  } sfr_op_s;

endpackage : sfr_pkg

// >>> logic/sfr_read_engine.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - 03h takes 3 or 4 address bytes by wide flag; 13h always four.
// - Only address bits 23 down to 0 are decoded; higher bits ignored.
// - Plain read: opcode, address on serial in; data out MSB first, no dummy.
// - Read address increments after each byte, wrapping to zero at the top.
// - Read opcodes arriving while a write is in progress are discarded.
// - After a plain read address, serial input is ignored until deselect.
// - Single-line fast read: address then configurable dummy, eight default.
// - Single-line fast read data driven on serial out at falling edges.
// - Four-line mode: opcode 2 clocks, address 6 or 8, dummy default six.
// - Four-line mode data leaves on all four lanes per falling edge.
// - EBh, 4Bh, 68h use four-line framing; the last two three-byte only.
// - Pause pin low with clock low pauses; high with clock low resumes.
// - While paused outputs float and input is ignored.
// - Pause disabled in double rate, quad enable, four-line mode, or pin used as reset.
// - Dual I/O read address two bits per rise, higher bit on lane one.
// - Dual I/O read data two bits per fall, MSB on lane one.
// - Mode byte in first four dummy clocks; nibble 1010 skips next opcode.
// - Other nibble leaves opcode skip; line mode setting is kept.
// - Dummy count includes mode clocks; four means data right after mode.
module sfr_read_engine
  import sfr_pkg::*;
(
  input  wire logic        clk,     // 10 MHz system clock
  input  wire logic        rstn,    // Async reset, active low
  input  wire logic        sckPin,  // Link clock from host
  input  wire logic        csPinN,  // Chip select, active low
  input  wire logic [3:0]  ioIn,    // Lane inputs, lane three is pause pin
  output logic      [3:0]  ioOut,   // Lane output values
  output logic      [3:0]  ioOeN,   // Lane drive enables, low drives
  input  wire sfr_cfg_s    cfg,     // Configuration and busy status
  output logic      [23:0] memAddr, // Array read address
  input  wire logic [7:0]  memData, // Array byte, valid a cycle after memAddr
  input  wire logic [7:0]  awaddr,  // AXI write address
  input  wire logic        awvalid, // AXI write address valid
  output logic             awready, // AXI write address ready
  input  wire logic [31:0] wdata,   // AXI write data
  input  wire logic [3:0]  wstrb,   // AXI write strobes
  input  wire logic        wvalid,  // AXI write data valid
  output logic             wready,  // AXI write data ready
  output logic      [1:0]  bresp,   // AXI write response
  output logic             bvalid,  // AXI write response valid
  input  wire logic        bready,  // AXI write response ready
  input  wire logic [7:0]  araddr,  // AXI read address
  input  wire logic        arvalid, // AXI read address valid
  output logic             arready, // AXI read address ready
  output logic      [31:0] rdata,   // AXI read data
  output logic      [1:0]  rresp,   // AXI read response
  output logic             rvalid,  // AXI read data valid
  input  wire logic        rready   // AXI read data ready
);

  // Register map decode, shared by both bus directions
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ADDR);
  endfunction : isMapped

  // Opcode decode; four-line mode changes which opcodes are legal
  function automatic sfr_op_s decodeOp(input logic [7:0] opc,
                                       input logic four_line_command_mode, input logic wf);
    sfr_op_s d;
    d = '0;
    case (opc)
      OPC_PLAIN:      d = '{ok: !four_line_command_mode, kind: KIND_PLAIN, wide: wf};
      OPC_PLAIN_WIDE: d = '{ok: !four_line_command_mode, kind: KIND_PLAIN, wide: 1'b1};
      OPC_FAST:       d = '{ok: 1'b1, kind: KIND_FAST, wide: wf};
      OPC_FAST_WIDE:  d = '{ok: 1'b1, kind: KIND_FAST, wide: 1'b1};
      OPC_DUAL:       d = '{ok: !four_line_command_mode, kind: KIND_DUAL, wide: wf};
      OPC_DUAL_WIDE:  d = '{ok: !four_line_command_mode, kind: KIND_DUAL, wide: 1'b1};
      OPC_QUAD:       d = '{ok: four_line_command_mode, kind: KIND_FAST, wide: wf};
      OPC_UID,
      OPC_INFO:       d = '{ok: four_line_command_mode, kind: KIND_FAST, wide: 1'b0};
      default:        d = '0;
    endcase
    decodeOp = d;
  endfunction : decodeOp

  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  logic              sckPrev_r;
  logic              csPrev_r;
  logic              pause_r;
  sfr_cfg_s          cfg_r;
  sfr_state_e        state_r;
  sfr_kind_e         kind_r;
  logic              wide_r;
  logic              skip_r;
  logic              skipWide_r;
  logic [7:0]        opc_r;
  logic [31:0]       addr_r;
  logic [5:0]        bitCnt_r;
  logic [4:0]        dummyCnt_r;
  logic [7:0]        mode_r;
  logic [2:0]        modeCnt_r;
  logic [7:0]        sh_r;
  logic [2:0]        dataCnt_r;
  logic [3:0]        ioOut_r;
  logic [3:0]        ioOeN_r;
  logic [23:0]       memAddr_r;
  logic              ctrlEnable_r;

  // Two-flop synchroniser for every pin; only syncB_r is read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= '1;
      syncB_r <= '1;
    end else begin
      syncA_r <= {sckPin, csPinN, ioIn};
      syncB_r <= syncA_r;
    end
  end

  logic       sckNow;
  logic       csNow;
  logic [3:0] ioNow;
  assign sckNow = syncB_r[5];
  assign csNow  = syncB_r[4];
  assign ioNow  = syncB_r[3:0];

  // Edge finding on the sampled link clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sckPrev_r <= 1'b1; // Matches synchroniser reset, no false edge
      csPrev_r  <= 1'b1;
    end else begin
      sckPrev_r <= sckNow;
      csPrev_r  <= csNow;
    end
  end

  logic csFall;
  logic riseE;
  logic fallE;
  logic pauseAllowed;
  assign csFall = !csNow && csPrev_r;
  assign riseE  = sckNow && !sckPrev_r && !csNow && !pause_r;
  assign fallE  = !sckNow && sckPrev_r && !csNow && !pause_r;
  assign pauseAllowed = !cfg_r.quadEnableBit && !cfg_r.doubleRate
                     && !cfg_r.pinIsReset && !cfg_r.fourLineCommandMode;

  // Pause follows the pin only while the clock is low; sequence state kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pause_r <= 1'b0;
    end else if (csNow || !pauseAllowed) begin
      pause_r <= 1'b0;
    end else if (!sckNow) begin
      pause_r <= !ioNow[3];
    end
  end

  // Lanes per clock: opcode phase sees kind PLAIN, so 1 or 4
  logic [2:0]  lanes;
  logic [7:0]  opcNext;
  logic [31:0] addrNext;
  logic [5:0]  bitSum;
  logic [5:0]  addrLen;
  logic [4:0]  dummyLoad;
  logic [7:0]  modeNext;
  sfr_op_s     opDec;
  assign lanes = cfg_r.fourLineCommandMode ? 3'd4 :
                 (kind_r == KIND_DUAL) ? 3'd2 : 3'd1;
  assign bitSum  = bitCnt_r + {3'b000, lanes};
  assign opcNext = cfg_r.fourLineCommandMode ? {opc_r[3:0], ioNow}
                                             : {opc_r[6:0], ioNow[0]};
  assign addrNext = (lanes == 3'd4) ? {addr_r[27:0], ioNow} :
                    (lanes == 3'd2) ? {addr_r[29:0], ioNow[1:0]} :
                                      {addr_r[30:0], ioNow[0]};
  assign addrLen  = wide_r ? ADDR_BITS_WIDE : ADDR_BITS_SHORT;
  assign opDec    = decodeOp(opcNext, cfg_r.fourLineCommandMode,
                             cfg_r.wideAddressFlag);
  assign dummyLoad = (kind_r == KIND_PLAIN) ? 5'd0 :
                     (kind_r == KIND_DUAL) ? cfg_r.dummyDual :
                     cfg_r.fourLineCommandMode ? cfg_r.dummyQuad
                                               : cfg_r.dummySingle;
  assign modeNext = {mode_r[5:0], ioNow[1:0]};

  logic addrDone;
  assign addrDone = riseE && (state_r == ST_ADDR) && (bitSum == addrLen);

  // Settings captured once per transaction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '{wideAddressFlag: 1'b0, dummySingle: DUMMY_SINGLE_RST,
                 dummyQuad: DUMMY_QUAD_RST, dummyDual: DUMMY_DUAL_RST,
                 default: 1'b0};
    end else if (csFall) begin
      cfg_r <= cfg;
    end
  end

  // Command sequencer, advanced by link clock rising edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= ST_IDLE;
      kind_r     <= KIND_PLAIN;
      wide_r     <= 1'b0;
      skip_r     <= 1'b0;
      skipWide_r <= 1'b0;
      opc_r      <= 8'h00;
      addr_r     <= 32'h0000_0000;
      bitCnt_r   <= 6'd0;
      dummyCnt_r <= 5'd0;
      mode_r     <= 8'h00;
      modeCnt_r  <= 3'd0;
    end else if (csNow) begin
      state_r <= ST_IDLE;
    end else if (csFall) begin
      bitCnt_r  <= 6'd0;
      modeCnt_r <= 3'd0;
      if (cfg.writeInProgress || !ctrlEnable_r) begin
        state_r <= ST_IGNORE;
      end else if (skip_r) begin
        state_r <= ST_ADDR;
        kind_r  <= KIND_DUAL;
        wide_r  <= skipWide_r;
      end else begin
        state_r <= ST_OPCODE;
        kind_r  <= KIND_PLAIN;
      end
    end else if (riseE) begin
      case (state_r)
        ST_OPCODE: begin
          opc_r    <= opcNext;
          bitCnt_r <= bitSum;
          if (bitSum == OPC_BITS) begin
            bitCnt_r <= 6'd0;
            kind_r   <= opDec.kind;
            wide_r   <= opDec.wide;
            state_r  <= opDec.ok ? ST_ADDR : ST_IGNORE;
          end
        end
        ST_ADDR: begin
          addr_r   <= addrNext;
          bitCnt_r <= bitSum;
          if (addrDone) begin
            dummyCnt_r <= dummyLoad;
            state_r    <= (dummyLoad == 5'd0) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          dummyCnt_r <= dummyCnt_r - 5'd1;
          if (dummyCnt_r == 5'd1) begin
            state_r <= ST_DATA;
          end
          if (kind_r == KIND_DUAL && modeCnt_r < MODE_CLOCKS) begin
            mode_r    <= modeNext;
            modeCnt_r <= modeCnt_r + 3'd1;
            if (modeCnt_r == MODE_CLOCKS - 3'd1) begin
              skip_r     <= (modeNext[7:4] == SKIP_NIBBLE);
              skipWide_r <= wide_r;
            end
          end
        end
        ST_DATA:   state_r <= ST_DATA;
        ST_IGNORE: state_r <= ST_IGNORE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // Output lane selection for 1, 2 or 4 lanes
  logic [7:0] byteCur;
  logic [3:0] outBits;
  logic [3:0] oeMask;
  assign byteCur = (dataCnt_r == 3'd0) ? memData : sh_r;
  assign outBits = (lanes == 3'd4) ? byteCur[7:4] :
                   (lanes == 3'd2) ? {2'b00, byteCur[7:6]} :
                                     {2'b00, byteCur[7], 1'b0};
  assign oeMask  = (lanes == 3'd4) ? 4'h0 :
                   (lanes == 3'd2) ? 4'hc : 4'hd;

  // Data driver on falling edges; array address walks byte by byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ioOut_r   <= 4'h0;
      ioOeN_r   <= 4'hf;
      sh_r      <= 8'h00;
      dataCnt_r <= 3'd0;
      memAddr_r <= 24'h00_0000;
    end else begin
      if (addrDone) begin
        memAddr_r <= addrNext[TOP_DECODED_BIT:0];
        dataCnt_r <= 3'd0;
      end
      if (fallE && state_r == ST_DATA) begin
        ioOut_r   <= outBits;
        ioOeN_r   <= oeMask;
        sh_r      <= byteCur << lanes;
        dataCnt_r <= dataCnt_r + lanes;
        if (dataCnt_r == 3'd0) begin
          memAddr_r <= memAddr_r + 24'd1;
        end
      end else if (csNow || pause_r || state_r != ST_DATA) begin
        ioOeN_r <= 4'hf;
      end
    end
  end

  assign ioOut   = ioOut_r;
  assign ioOeN   = ioOeN_r;
  assign memAddr = memAddr_r;

  // AXI4-Lite slave; one write and one read in flight at most
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] statusWord;
  logic [31:0] readWord;
  assign statusWord = {25'd0, !csNow, pause_r, skip_r, 1'b0, state_r};
  assign readWord = (araddr == REG_CTRL) ? {31'd0, ctrlEnable_r} :
                    (araddr == REG_STATUS) ? statusWord :
                    (araddr == REG_ADDR) ? {8'h00, memAddr_r} : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      ctrlEnable_r <= CTRL_ENABLE_RST;
    end else begin
      if (awvalid && awready_r) begin
        awHeld_r  <= 1'b1;
        awAddr_r  <= awaddr;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wHeld_r  <= 1'b1;
        wData_r  <= wdata;
        wStrb_r  <= wstrb;
        wready_r <= 1'b0;
      end
      if (awHeld_r && wHeld_r && !bvalid_r) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_DECERR;
        if (awAddr_r == REG_CTRL && wStrb_r[0]) begin
          ctrlEnable_r <= wData_r[CTRL_ENABLE_BIT];
        end
      end
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= readWord;
      rresp_r   <= isMapped(araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Checks on the sequencer and lane drivers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_busy_discard: assert property (
    csFall && cfg.writeInProgress |=> state_r == ST_IGNORE)
    else $error("read taken while write in progress");
  chk_ignore_quiet: assert property (
    state_r == ST_IGNORE |=> ioOeN_r == 4'hf)
    else $error("lanes driven in ignored transaction");
  chk_pause_float: assert property (
    pause_r |=> ioOeN_r == 4'hf)
    else $error("lanes driven while paused");
  chk_pause_blocked: assert property (
    !pauseAllowed |=> !pause_r)
    else $error("pause active while not allowed");
  chk_addr_walk: assert property (
    fallE && state_r == ST_DATA && dataCnt_r == 3'd0 && !addrDone
    |=> memAddr_r == $past(memAddr_r) + 24'd1)
    else $error("read address did not advance");
  chk_plain_nodummy: assert property (
    addrDone && kind_r == KIND_PLAIN |=> state_r == ST_DATA)
    else $error("plain read entered dummy phase");
  chk_addr_length: assert property (
    addrDone && kind_r == KIND_PLAIN
    |-> bitSum == ((opc_r == OPC_PLAIN_WIDE || cfg_r.wideAddressFlag)
                   ? ADDR_BITS_WIDE : ADDR_BITS_SHORT))
    else $error("address length wrong");
  chk_skip_entry: assert property (
    csFall && skip_r && !cfg.writeInProgress && ctrlEnable_r
    |=> state_r == ST_ADDR && kind_r == KIND_DUAL)
    else $error("opcode skip not taken");
  chk_dual_lanes: assert property (
    state_r == ST_DATA && kind_r == KIND_DUAL && !csNow
    |-> ioOeN_r inside {4'hc, 4'hf})
    else $error("dual read drives wrong lanes");
  chk_single_lane: assert property (
    state_r == ST_DATA && lanes == 3'd1 |-> ioOeN_r inside {4'hd, 4'hf})
    else $error("single read drives wrong lanes");

  cov_plain_data: cover property (
    state_r == ST_DATA && kind_r == KIND_PLAIN && fallE);
  cov_skip_set: cover property (!skip_r ##1 skip_r);
  cov_quad_data: cover property (state_r == ST_DATA && lanes == 3'd4);
  cov_pause: cover property (state_r == ST_DATA && pause_r);

endmodule : sfr_read_engine

// >>> dv/sfr_host_model.sv
`timescale 1ns/10ps
module sfr_host_model (
  input  wire logic       clk,    // System clock
  input  wire logic [3:0] ioOut,  // Device lane values
  input  wire logic [3:0] ioOeN,  // Device lane enables, low drives
  output logic            sckPin, // Link clock, low outside frames
  output logic            csPinN, // Chip select, active low
  output logic      [3:0] ioIn    // Resolved lane levels
);
  logic [3:0] hOut; // Host lane values
  logic [3:0] hOe;  // Host drives lane when high

  // Lane level: device first, then host, else the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ioIn[i] = !ioOeN[i] ? ioOut[i] : (hOe[i] ? hOut[i] : 1'b1);
    end
  end

  initial begin
    sckPin = 1'b0;
    csPinN = 1'b1;
    hOut = 4'h8;
    hOe = 4'h8;
  end

  // Half a link period is four system clocks
  task automatic half(input logic lvl);
    sckPin <= lvl;
    repeat (4) @(posedge clk);
  endtask : half

  // Host drives on falls and samples just before each rise
  task automatic xfer(input logic [7:0] op, input logic skipOp,
      input logic [31:0] ad, input int aBits, input int lanes,
      input int dummy, input logic [7:0] mode, input int nb,
      output logic [63:0] got, input int pz = -1);
    got = '0;
    @(posedge clk);
    csPinN <= 1'b0;
    hOe <= 4'h9; // Pause pin held high
    hOut <= 4'h8;
    repeat (4) @(posedge clk);
    for (int b = 7; b >= 0 && !skipOp; b -= (lanes == 4) ? 4 : 1) begin
      if (lanes == 4) begin
        hOe <= 4'hf;
        hOut <= op[b-:4];
      end else hOut <= {3'b100, op[b]};
      half(1'b0);
      half(1'b1);
    end
    for (int b = aBits - 1; b >= 0; b -= lanes) begin
      if (lanes == 1) hOut <= {3'b100, ad[b]};
      else if (lanes == 2) begin
        hOe <= 4'hb;
        hOut <= {2'b10, ad[b], ad[b-1]};
      end else begin
        hOe <= 4'hf;
        hOut <= ad[b-:4];
      end
      half(1'b0);
      half(1'b1);
    end
    for (int i = 0; i < dummy; i++) begin
      if (lanes == 2 && i < 2) hOut <= {2'b10, mode[7-2*i], mode[6-2*i]};
      else hOe <= 4'h8;
      half(1'b0);
      half(1'b1);
    end
    hOe <= 4'h8;
    for (int k = 0; k < nb * 8 / lanes; k++) begin
      half(1'b0);
      if (lanes == 1) got = {got[62:0], ioIn[1]};
      else if (lanes == 2) got = {got[61:0], ioIn[1:0]};
      else got = {got[59:0], ioIn};
      // Pause with clock low, toggle the clock, resume with clock low
      if (k == pz) begin
        hOut[3] <= 1'b0;
        half(1'b0);
        half(1'b1);
        half(1'b0);
        hOut[3] <= 1'b1;
        half(1'b0);
      end
      half(1'b1);
    end
    half(1'b0);
    csPinN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : sfr_host_model

// >>> dv/sfr_read_engine_test.sv
`timescale 1ns/10ps
module sfr_read_engine_test;
  import sfr_pkg::*;
  logic        clk, rstn, sckPin, csPinN;
  logic [3:0]  ioIn, ioOut, ioOeN, wstrb;
  sfr_cfg_s    cfg;
  logic [23:0] memAddr;
  logic [7:0]  memData, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [63:0] got;
  int          err_total, total_checks;

  sfr_read_engine dut (.clk(clk), .rstn(rstn), .sckPin(sckPin),
    .csPinN(csPinN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN),
    .cfg(cfg), .memAddr(memAddr), .memData(memData), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  sfr_host_model host (.clk(clk), .ioOut(ioOut), .ioOeN(ioOeN),
    .sckPin(sckPin), .csPinN(csPinN), .ioIn(ioIn));

  // Array stand-in, byte one cycle after the address
  always_ff @(posedge clk) memData <= memAddr[7:0] ^ 8'h3c;

  function automatic logic [7:0] exb(input logic [23:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : exb

  task automatic chk(input string nm, input logic [63:0] s,
      input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Write: both channels offered together, each dropped once taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bvalid", n, 3);
    chk("bresp", bresp, er);
    @(posedge clk);
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rvalid", n, 2);
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    @(posedge clk);
  endtask : axiRd

  task automatic testRegs;
    axiRd(REG_CTRL, 32'h1, RESP_OKAY);
    axiRd(REG_STATUS, 32'h0, RESP_OKAY);
    axiRd(8'h40, 32'h0, RESP_DECERR);
    axiWr(8'h40, 32'h0, RESP_DECERR);
    axiWr(REG_STATUS, 32'hff, RESP_OKAY);
    axiRd(REG_CTRL, 32'h1, RESP_OKAY);
    $display("registers done");
  endtask : testRegs

  task automatic testPlain;
    host.xfer(OPC_PLAIN, 0, 32'hfffffe, 24, 1, 0, 8'h0, 3, got);
    chk("plain wrap", got[23:0],
        {exb(24'hfffffe), exb(24'hffffff), exb(24'h0)});
    host.xfer(OPC_PLAIN_WIDE, 0, 32'hab000010, 32, 1, 0, 8'h0, 2, got);
    chk("wide op", got[15:0], {exb(24'h10), exb(24'h11)});
    cfg.wideAddressFlag <= 1'b1;
    host.xfer(OPC_PLAIN, 0, 32'h7f000123, 32, 1, 0, 8'h0, 1, got);
    chk("wide flag", got[7:0], exb(24'h123));
    cfg.wideAddressFlag <= 1'b0;
    $display("plain read done");
  endtask : testPlain

  task automatic testFast;
    host.xfer(OPC_FAST, 0, 32'h000456, 24, 1, 8, 8'h0, 2, got);
    chk("fast", got[15:0], {exb(24'h456), exb(24'h457)});
    host.xfer(OPC_FAST_WIDE, 0, 32'h01000080, 32, 1, 8, 8'h0, 1, got);
    chk("fast wide", got[7:0], exb(24'h80));
    cfg.fourLineCommandMode <= 1'b1;
    host.xfer(OPC_FAST, 0, 32'h000789, 24, 4, 6, 8'h0, 2, got);
    chk("quad", got[15:0], {exb(24'h789), exb(24'h78a)});
    cfg.fourLineCommandMode <= 1'b0;
    host.xfer(OPC_UID, 0, 32'h0, 24, 1, 8, 8'h0, 1, got);
    chk("uid single", got[7:0], 8'hff);
    $display("fast read done");
  endtask : testFast

  task automatic testDual;
    host.xfer(OPC_DUAL, 0, 32'h0000a5, 24, 2, 4, 8'ha0, 2, got);
    chk("dual", got[15:0], {exb(24'ha5), exb(24'ha6)});
    host.xfer(8'h0, 1, 32'h000033, 24, 2, 4, 8'hf0, 1, got);
    chk("skip op", got[7:0], exb(24'h33));
    host.xfer(OPC_DUAL_WIDE, 0, 32'hff000071, 32, 2, 4, 8'h0, 1, got);
    chk("skip left", got[7:0], exb(24'h71));
    $display("dual read done");
  endtask : testDual

  // Pause after bit four; with quad enable the pin is ignored, a bit slips
  task automatic testPause;
    host.xfer(OPC_PLAIN, 0, 32'h10, 24, 1, 0, 8'h0, 1, got, 3);
    chk("pause", got[7:0], exb(24'h10));
    cfg.quadEnableBit <= 1'b1;
    host.xfer(OPC_PLAIN, 0, 32'h10, 24, 1, 0, 8'h0, 1, got, 3);
    chk("pause off", got[7:0], 8'h28);
    cfg.quadEnableBit <= 1'b0;
    $display("pause done");
  endtask : testPause

  // Refused reads leave the lanes floating at the pull-up
  task automatic testRefuse;
    cfg.writeInProgress <= 1'b1;
    host.xfer(OPC_PLAIN, 0, 32'h0, 24, 1, 0, 8'h0, 1, got);
    chk("busy", got[7:0], 8'hff);
    cfg.writeInProgress <= 1'b0;
    axiWr(REG_CTRL, 32'h0, RESP_OKAY);
    host.xfer(OPC_PLAIN, 0, 32'h0, 24, 1, 0, 8'h0, 1, got);
    chk("disabled", got[7:0], 8'hff);
    axiWr(REG_CTRL, 32'h1, RESP_OKAY);
    host.xfer(OPC_PLAIN, 0, 32'h0, 24, 1, 0, 8'h0, 1, got);
    chk("enabled", got[7:0], exb(24'h0));
    axiRd(REG_ADDR, 32'h2, RESP_OKAY);
    $display("refusal done");
  endtask : testRefuse

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, well past the expected run length
  initial begin
    #5000000;
    err_total++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    cfg = '0;
    cfg.dummySingle = DUMMY_SINGLE_RST;
    cfg.dummyQuad = DUMMY_QUAD_RST;
    cfg.dummyDual = DUMMY_DUAL_RST;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    testRegs();
    testPlain();
    testFast();
    testDual();
    testPause();
    testRefuse();
    print_verdict();
  end
endmodule : sfr_read_engine_test
